/* File: common/mft_map.svh */
// register offsets, field codes and reset values of the dual timer
// Summary of operation
// - both counters stay stopped after reset until software sets them up
// - pwm mode: counter one reloads alternately from register a then b
// - pwm mode: first reload after any stop or restart comes from a
// - pwm mode: pin a inverts on each counter one underflow when enabled
// - pwm mode: reload from a sets pending a, from b sets pending b
// - pwm and dual capture: counter two underflow sets pending d
// - dual capture: edges on pins a and b copy counter one to a, b
// - each capture input selects rising or falling edge on its own
// - preset on capture: copy counter first, then load all ones
// - dual capture: capture a, capture b, counter one underflow events
// - capture modes: pin b clock selections stop the counter
// - timer modes: counter one reloads from a, pin a toggles if enabled
// - timer modes: pin a low to high sets pending c, gated by enable a
// - software sets pin a level before the first toggle
// - dual timer: pin b event or accumulate clocks either counter
// - dual timer: counter two reloads from b, underflow sets pending d
// - capture plus timer: pin b edge captures counter two, optional preset
// - capture plus timer: capture b and counter two underflow events
// - sources a to c drive timer interrupt one, source d interrupt two
// - mode field 00 pwm, 01 dual capture, 10 dual timer
// - clock select codes: none, prescaled, event, accumulate, slow
`ifndef MFT_MAP_SVH
`define MFT_MAP_SVH
`define MFT_OFS_CNT1 8'h00
`define MFT_OFS_RLDA 8'h04
`define MFT_OFS_RLDB 8'h08
`define MFT_OFS_CNT2 8'h0C
`define MFT_OFS_PSC 8'h10
`define MFT_OFS_CLK 8'h14
`define MFT_OFS_MODE 8'h18
`define MFT_OFS_IRQ 8'h1C
`define MFT_OFS_CLR 8'h20
`define MFT_CS_NONE 3'h0
`define MFT_CS_PRESC 3'h1
`define MFT_CS_EXT 3'h2
`define MFT_CS_ACC 3'h3
`define MFT_CS_SLOW 3'h4
`define MFT_ZERO16 16'h0000
`define MFT_ONE16 16'h0001
`define MFT_ONES16 16'hFFFF
`define MFT_ZERO32 32'h0000_0000
`define MFT_PSC_RST 5'h00
`define MFT_PSC_ONE 5'h01
`define MFT_CTL_RST 8'h00
`define MFT_NIB_RST 4'h0
`define MFT_LOW 1'b0
`define MFT_HIGH 1'b1
`define MFT_RESP_OKAY 2'h0
`define MFT_RESP_SLVERR 2'h2
`endif

/* File: common/mft_pkg.sv */
// types shared by the dual timer blocks
package mft_pkg;
  typedef enum logic [1:0] {
    mft_pwm = 2'h0,
    mft_dcap = 2'h1,
    mft_dtmr = 2'h2,
    mft_scap = 2'h3
  } mft_mode_t;
  typedef enum logic [1:0] {
    mft_wr_idle = 2'h1,
    mft_wr_resp = 2'h2
  } mft_wr_st_t;
  typedef struct packed {
    logic enable;
    logic pin_a_init;
    logic pin_b_function_enable;
    logic pin_a_function_enable;
    logic edge_b;
    logic edge_a;
    mft_mode_t mode_field;
  } mft_mode_ctl_t;
  typedef struct packed {
    logic [1:0] spare;
    logic [2:0] counter_two_clock_select;
    logic [2:0] counter_one_clock_select;
  } mft_clk_ctl_t;
endpackage : mft_pkg

/* File: logic/mft_prescale.sv */
// system clock prescaler giving one tick every divisor plus one cycles
`timescale 1ns/10ps
`include "mft_map.svh"
module mft_prescale (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // divisor and tick
  input wire logic [4:0] div_val,
  output logic tick
);
  logic [4:0] cnt_ff;

  // down counter, reloaded with the divisor when it reaches zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff <= `MFT_PSC_RST;
    end else if (cnt_ff == `MFT_PSC_RST) begin
      cnt_ff <= div_val;
    end else begin
      cnt_ff <= cnt_ff - `MFT_PSC_ONE;
    end
  end

  assign tick = (cnt_ff == `MFT_PSC_RST);
endmodule : mft_prescale

/* File: logic/mft_pinsync.sv */
// two flop synchroniser with selectable edge detection
`timescale 1ns/10ps
`include "mft_map.svh"
module mft_pinsync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // raw pin and edge choice
  input wire logic pin,
  input wire logic fall_sel,
  // synchronised level and edge pulse
  output logic lvl,
  output logic edge_hit
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // first flop feeds only the second; third keeps the previous level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= `MFT_LOW;
      s2_ff <= `MFT_LOW;
      s3_ff <= `MFT_LOW;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a level held one clock or longer is seen as one edge
  assign lvl = s2_ff;
  assign edge_hit = fall_sel ? (s3_ff & ~s2_ff) : (s2_ff & ~s3_ff);
endmodule : mft_pinsync

/* File: logic/mft_top.sv */
// dual 16-bit timer with pwm, capture and timer modes on an axi4-lite slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "mft_map.svh"
module mft_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer pins
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  input wire logic timer_pin_b_in,
  input wire logic slow_clk_in,
  // system interrupts
  output logic irq_timer1,
  output logic irq_timer2
);
  import mft_pkg::*;

  logic [15:0] counter_one_ff;
  logic [15:0] counter_two_ff;
  logic [15:0] reload_capture_a_ff;
  logic [15:0] reload_capture_b_ff;
  logic [4:0] prescale_ff;
  mft_clk_ctl_t clk_ctl_ff;
  mft_mode_ctl_t mode_ctl_ff;
  logic [3:0] irq_en_ff;
  logic [3:0] pend_ff;
  logic sel_b_ff;
  logic pin_a_out_ff;
  logic pin_a_oe_ff;
  logic irq1_ff;
  logic irq2_ff;
  mft_wr_st_t wr_st_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_word;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // offset lies on the register map
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = ({a[7:2], 2'b00} <= `MFT_OFS_CLR);
  endfunction : addr_ok

  // counter clock from its select code; pin b sources die in capture modes
  function automatic logic clk_tick(input logic [2:0] sel, input logic cap,
                                    input logic ps, input logic ext,
                                    input logic acc, input logic slow);
    case (sel)
      `MFT_CS_NONE: clk_tick = `MFT_LOW;
      `MFT_CS_PRESC: clk_tick = ps;
      `MFT_CS_EXT: clk_tick = ext & ~cap;
      `MFT_CS_ACC: clk_tick = acc & ~cap;
      `MFT_CS_SLOW: clk_tick = slow;
      default: clk_tick = `MFT_LOW;
    endcase
  endfunction : clk_tick

  // ---- axi4-lite write side
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire do_wr = (wr_st_ff == mft_wr_idle) & aw_got_ff & w_got_ff;
  wire [7:0] wa = {waddr_ff[7:2], 2'b00};
  wire wr_cnt1 = do_wr & (wa == `MFT_OFS_CNT1);
  wire wr_rlda = do_wr & (wa == `MFT_OFS_RLDA);
  wire wr_rldb = do_wr & (wa == `MFT_OFS_RLDB);
  wire wr_cnt2 = do_wr & (wa == `MFT_OFS_CNT2);
  wire [3:0] clr = (do_wr & (wa == `MFT_OFS_CLR) & wstrb_ff[0]) ?
                   wdata_ff[3:0] : `MFT_NIB_RST;

  // address and data are taken in either order and held until used
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_got_ff <= `MFT_LOW;
      w_got_ff <= `MFT_LOW;
      awready_ff <= `MFT_LOW;
      wready_ff <= `MFT_LOW;
      waddr_ff <= `MFT_CTL_RST;
      wdata_ff <= `MFT_ZERO32;
      wstrb_ff <= `MFT_NIB_RST;
    end else begin
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_got_ff <= aw_hs | (aw_got_ff & ~do_wr);
      w_got_ff <= w_hs | (w_got_ff & ~do_wr);
      awready_ff <= ~(aw_hs | (aw_got_ff & ~do_wr));
      wready_ff <= ~(w_hs | (w_got_ff & ~do_wr));
    end
  end

  // write response state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_st_ff <= mft_wr_idle;
      bvalid_ff <= `MFT_LOW;
      bresp_ff <= `MFT_RESP_OKAY;
    end else begin
      case (wr_st_ff)
        mft_wr_idle: begin
          if (do_wr) begin
            wr_st_ff <= mft_wr_resp;
            bvalid_ff <= `MFT_HIGH;
            bresp_ff <= addr_ok(waddr_ff) ? `MFT_RESP_OKAY : `MFT_RESP_SLVERR;
          end
        end
        mft_wr_resp: begin
          if (s_axi_bready) begin
            wr_st_ff <= mft_wr_idle;
            bvalid_ff <= `MFT_LOW;
          end
        end
        default: begin
          wr_st_ff <= mft_wr_idle;
          bvalid_ff <= `MFT_LOW;
        end
      endcase
    end
  end

  // ---- axi4-lite read side
  wire ar_hs = s_axi_arvalid & arready_ff;

  // read multiplexer
  always_comb begin
    rd_word = `MFT_ZERO32;
    case ({s_axi_araddr[7:2], 2'b00})
      `MFT_OFS_CNT1: rd_word[15:0] = counter_one_ff;
      `MFT_OFS_RLDA: rd_word[15:0] = reload_capture_a_ff;
      `MFT_OFS_RLDB: rd_word[15:0] = reload_capture_b_ff;
      `MFT_OFS_CNT2: rd_word[15:0] = counter_two_ff;
      `MFT_OFS_PSC: rd_word[4:0] = prescale_ff;
      `MFT_OFS_CLK: rd_word[7:0] = clk_ctl_ff;
      `MFT_OFS_MODE: rd_word[7:0] = mode_ctl_ff;
      `MFT_OFS_IRQ: rd_word[7:0] = {pend_ff, irq_en_ff};
      default: rd_word = `MFT_ZERO32;
    endcase
  end

  // one read under way; data held until taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_ff <= `MFT_LOW;
      rvalid_ff <= `MFT_LOW;
      rdata_ff <= `MFT_ZERO32;
      rresp_ff <= `MFT_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rvalid_ff <= `MFT_HIGH;
        rdata_ff <= rd_word;
        rresp_ff <= addr_ok(s_axi_araddr) ? `MFT_RESP_OKAY : `MFT_RESP_SLVERR;
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff <= `MFT_LOW;
      end
      arready_ff <= ~(ar_hs | (rvalid_ff & ~s_axi_rready));
    end
  end

  // control registers, all cleared so both counters start stopped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale_ff <= `MFT_PSC_RST;
      clk_ctl_ff <= `MFT_CTL_RST;
      mode_ctl_ff <= `MFT_CTL_RST;
      irq_en_ff <= `MFT_NIB_RST;
    end else if (do_wr & wstrb_ff[0]) begin
      case (wa)
        `MFT_OFS_PSC: prescale_ff <= wdata_ff[4:0];
        `MFT_OFS_CLK: clk_ctl_ff <= {2'b00, wdata_ff[5:0]};
        `MFT_OFS_MODE: mode_ctl_ff <= wdata_ff[7:0];
        `MFT_OFS_IRQ: irq_en_ff <= wdata_ff[3:0];
        default: prescale_ff <= prescale_ff;
      endcase
    end
  end

  // ---- clock sources and pins
  logic ps_tick;
  logic pa_lvl;
  logic pa_edge;
  logic pb_lvl;
  logic pb_edge;
  logic slow_lvl;
  logic slow_edge;

  mft_prescale u_psc (
    .core_clk(core_clk),
    .rst(rst),
    .div_val(prescale_ff),
    .tick(ps_tick)
  );

  mft_pinsync u_sync_a (
    .core_clk(core_clk),
    .rst(rst),
    .pin(timer_pin_a_in),
    .fall_sel(mode_ctl_ff.edge_a),
    .lvl(pa_lvl),
    .edge_hit(pa_edge)
  );

  mft_pinsync u_sync_b (
    .core_clk(core_clk),
    .rst(rst),
    .pin(timer_pin_b_in),
    .fall_sel(mode_ctl_ff.edge_b),
    .lvl(pb_lvl),
    .edge_hit(pb_edge)
  );

  mft_pinsync u_sync_slow (
    .core_clk(core_clk),
    .rst(rst),
    .pin(slow_clk_in),
    .fall_sel(`MFT_LOW),
    .lvl(slow_lvl),
    .edge_hit(slow_edge)
  );

  // mode decode and counter clocks
  wire mft_mode_t mode = mode_ctl_ff.mode_field;
  wire is_cap = (mode == mft_dcap) | (mode == mft_scap);
  wire is_tmr = (mode == mft_dtmr) | (mode == mft_scap);
  wire en = mode_ctl_ff.enable;
  wire fe_a = mode_ctl_ff.pin_a_function_enable;
  wire fe_b = mode_ctl_ff.pin_b_function_enable;
  wire acc_tick = ps_tick & (pb_lvl ^ mode_ctl_ff.edge_b);
  wire [2:0] c1sel = clk_ctl_ff.counter_one_clock_select;
  wire [2:0] c2sel = clk_ctl_ff.counter_two_clock_select;
  wire c1_tick = en & clk_tick(c1sel, is_cap, ps_tick, pb_edge, acc_tick, slow_edge);
  wire c2_tick = en & clk_tick(c2sel, is_cap, ps_tick, pb_edge, acc_tick, slow_edge);
  wire c1_run = en & (c1sel != `MFT_CS_NONE);
  wire c1_uf = c1_tick & (counter_one_ff == `MFT_ZERO16);
  wire c2_uf = c2_tick & (counter_two_ff == `MFT_ZERO16);
  wire cap_a = en & pa_edge & (mode == mft_dcap);
  wire cap_b = en & pb_edge & is_cap;
  wire toggle_a = fe_a & c1_uf & (mode != mft_dcap);
  wire rise_a = toggle_a & ~pin_a_out_ff & is_tmr;

  // counter one: preset, reload, software load, then count down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_one_ff <= `MFT_ZERO16;
    end else if ((mode == mft_dcap) & ((cap_a & fe_a) | (cap_b & fe_b))) begin
      counter_one_ff <= `MFT_ONES16;
    end else if (c1_uf & (mode == mft_pwm)) begin
      counter_one_ff <= sel_b_ff ? reload_capture_b_ff : reload_capture_a_ff;
    end else if (c1_uf & is_tmr) begin
      counter_one_ff <= reload_capture_a_ff;
    end else if (wr_cnt1) begin
      counter_one_ff <= merge16(counter_one_ff, wdata_ff, wstrb_ff);
    end else if (c1_tick) begin
      counter_one_ff <= counter_one_ff - `MFT_ONE16;
    end
  end

  // counter two: capture preset, reload in dual timer, software load, count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_two_ff <= `MFT_ZERO16;
    end else if ((mode == mft_scap) & cap_b & fe_b) begin
      counter_two_ff <= `MFT_ONES16;
    end else if (c2_uf & (mode == mft_dtmr)) begin
      counter_two_ff <= reload_capture_b_ff;
    end else if (wr_cnt2) begin
      counter_two_ff <= merge16(counter_two_ff, wdata_ff, wstrb_ff);
    end else if (c2_tick) begin
      counter_two_ff <= counter_two_ff - `MFT_ONE16;
    end
  end

  // capture registers take the count before any preset lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reload_capture_a_ff <= `MFT_ZERO16;
      reload_capture_b_ff <= `MFT_ZERO16;
    end else begin
      if (cap_a) begin
        reload_capture_a_ff <= counter_one_ff;
      end else if (wr_rlda) begin
        reload_capture_a_ff <= merge16(reload_capture_a_ff, wdata_ff, wstrb_ff);
      end
      if (cap_b) begin
        reload_capture_b_ff <= (mode == mft_dcap) ? counter_one_ff : counter_two_ff;
      end else if (wr_rldb) begin
        reload_capture_b_ff <= merge16(reload_capture_b_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // pwm reload selector restarts on register a whenever counter one stops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_b_ff <= `MFT_LOW;
    end else if (~c1_run | (mode != mft_pwm)) begin
      sel_b_ff <= `MFT_LOW;
    end else if (c1_uf) begin
      sel_b_ff <= ~sel_b_ff;
    end
  end

  // pin a output: preset level while stopped, toggles on underflow
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_a_out_ff <= `MFT_LOW;
      pin_a_oe_ff <= `MFT_LOW;
    end else begin
      pin_a_oe_ff <= fe_a & (mode != mft_dcap);
      if (~c1_run) begin
        pin_a_out_ff <= mode_ctl_ff.pin_a_init;
      end else if (toggle_a) begin
        pin_a_out_ff <= ~pin_a_out_ff;
      end
    end
  end

  // pending bits: a new event wins over a clear in the same cycle
  wire [3:0] pend_set = {
    c2_uf,
    ((mode == mft_dcap) & c1_uf) | rise_a,
    ((mode == mft_pwm) & c1_uf & sel_b_ff) | cap_b,
    ((mode == mft_pwm) & c1_uf & ~sel_b_ff) | cap_a
  };
  wire [2:0] eff_en = {is_tmr ? irq_en_ff[0] : irq_en_ff[2], irq_en_ff[1:0]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_ff <= `MFT_NIB_RST;
      irq1_ff <= `MFT_LOW;
      irq2_ff <= `MFT_LOW;
    end else begin
      pend_ff <= (pend_ff & ~clr) | pend_set;
      irq1_ff <= |(pend_ff[2:0] & eff_en);
      irq2_ff <= pend_ff[3] & irq_en_ff[3];
    end
  end

  // output ports
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign timer_pin_a_out = pin_a_out_ff;
  assign timer_pin_a_oe = pin_a_oe_ff;
  assign irq_timer1 = irq1_ff;
  assign irq_timer2 = irq2_ff;

  // ---- checks
  property p_start_stopped;
    $past(rst) |-> (clk_ctl_ff == `MFT_CTL_RST) && !c1_tick && !c2_tick;
  endproperty
  a_start_stopped: assert property (p_start_stopped)
    else $error("counter clocked right after reset");

  property p_pwm_alt;
    (mode == mft_pwm) && c1_uf && !sel_b_ff
    |=> (counter_one_ff == $past(reload_capture_a_ff)) && pend_ff[0];
  endproperty
  a_pwm_alt: assert property (p_pwm_alt)
    else $error("pwm reload did not use register a");

  property p_first_a;
    !c1_run |=> !sel_b_ff;
  endproperty
  a_first_a: assert property (p_first_a)
    else $error("stopped counter kept reload b selected");

  property p_toggle;
    (mode == mft_pwm) && c1_uf && fe_a |=> pin_a_out_ff != $past(pin_a_out_ff);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin a did not toggle on underflow");

  property p_preset_a;
    (mode == mft_dcap) && cap_a && fe_a
    |=> (reload_capture_a_ff == $past(counter_one_ff)) && (counter_one_ff == `MFT_ONES16);
  endproperty
  a_preset_a: assert property (p_preset_a)
    else $error("capture a lost count or preset");

  property p_cap_stop;
    is_cap && ((c1sel == `MFT_CS_EXT) || (c1sel == `MFT_CS_ACC)) |-> !c1_tick;
  endproperty
  a_cap_stop: assert property (p_cap_stop)
    else $error("pin b clock used in capture mode");

  property p_rise_c;
    rise_a |=> pend_ff[2] && pin_a_out_ff ##1 irq1_ff || !irq_en_ff[0];
  endproperty
  a_rise_c: assert property (p_rise_c)
    else $error("rising pin a missed pending c");

  property p_tmr2;
    (mode == mft_dtmr) && c2_uf
    |=> (counter_two_ff == $past(reload_capture_b_ff)) && pend_ff[3];
  endproperty
  a_tmr2: assert property (p_tmr2)
    else $error("counter two reload or pending d wrong");

  property p_preset_b;
    (mode == mft_scap) && cap_b && fe_b
    |=> (reload_capture_b_ff == $past(counter_two_ff)) && (counter_two_ff == `MFT_ONES16);
  endproperty
  a_preset_b: assert property (p_preset_b)
    else $error("capture b lost count or preset");

  property p_hold_d;
    pend_ff[3] && !clr[3] |=> pend_ff[3];
  endproperty
  a_hold_d: assert property (p_hold_d)
    else $error("pending d dropped without clear");

  c_pwm_b: cover property ((mode == mft_pwm) && c1_uf && sel_b_ff);
  c_cap_a: cover property (cap_a && fe_a);
  c_irq2: cover property (c2_uf ##[1:4] irq2_ff);
  c_axi_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : mft_top

/* File: tb/mft_pin_model.sv */
// far side of the timer pins: capture sources and a slow clock
`timescale 1ns/10ps
module mft_pin_model (
  // clock
  input wire logic core_clk,
  // pin levels driven toward the timer
  output logic pin_a,
  output logic pin_b,
  output logic slow_clk
);
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b0;
    slow_clk = 1'b0;
  end
  // slow clock at one eighth of the core clock, inside the sync limit
  always begin
    repeat (4) @(posedge core_clk);
    slow_clk <= ~slow_clk;
  end
  // each level is held three cycles so the synchroniser sees it
  task automatic drive_a(input logic v);
    @(posedge core_clk);
    pin_a <= v;
    repeat (3) @(posedge core_clk);
  endtask : drive_a
  task automatic pulse_b();
    @(posedge core_clk);
    pin_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    pin_b <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse_b
endmodule : mft_pin_model

/* File: tb/testbench.sv */
// register level tests of the dual timer through its axi4-lite port
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
  import mft_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awready, wready, bvalid, arready, rvalid, pa_out, pa_oe, irq1, irq2;
  logic [1:0] bresp, rresp;
  logic m_a, m_b, slow, pa_wire;
  logic [31:0] d;
  int num_errors = 0, n_compared = 0, hi, lo;
  // pin a wire: timer drives when enabled, else the source
  assign pa_wire = pa_oe ? pa_out : m_a;
  mft_top dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .timer_pin_a_in(pa_wire), .timer_pin_a_out(pa_out),
    .timer_pin_a_oe(pa_oe), .timer_pin_b_in(m_b), .slow_clk_in(slow),
    .irq_timer1(irq1), .irq_timer2(irq2));
  mft_pin_model pins (.core_clk(core_clk), .pin_a(m_a), .pin_b(m_b), .slow_clk(slow));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // write one register; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) begin aw = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    v = rdata;
  endtask : rd
  // cycles spent at level v on pin a, bounded
  task automatic span(input logic v, output int n);
    n = 0;
    while (pa_out !== v && n < 300) begin @(posedge core_clk); n++; end
    n = 0;
    while (pa_out === v && n < 300) begin @(posedge core_clk); n++; end
  endtask : span
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i <= 8; i++) begin
      rd(8'(i * 4), d);
      `CHK(d, 32'h0000_0000)
    end
    rd(8'h24, d);
    `CHK(rresp, 2'h2)
    $display("test reset done");
    // pwm: high lasts reload a + 1, low reload b + 1, also after restart
    wr(8'h04, 16'h0003);
    wr(8'h08, 16'h0005);
    wr(8'h1C, 16'h0003);
    wr(8'h18, 16'h0090);
    for (int k = 0; k < 2; k++) begin
      wr(8'h14, 16'h0001);
      span(1'b0, hi);
      span(1'b0, lo);
      span(1'b1, hi);
      span(1'b0, lo);
      `CHK(hi, 4)
      `CHK(lo, 6)
      wr(8'h14, 16'h0000);
      wr(8'h00, 16'h0000);
    end
    rd(8'h1C, d);
    `CHK(d[15:0], 16'h0033)
    `CHK(irq1, 1'b1)
    wr(8'h18, 16'h0000);
    wr(8'h20, 16'h000F);
    repeat (3) @(posedge core_clk);
    `CHK(irq1, 1'b0)
    $display("test pwm done");
    // dual capture on stopped counter: b rising with preset, a falling
    wr(8'h18, 16'h00A5);
    wr(8'h00, 16'h1234);
    pins.pulse_b();
    repeat (4) @(posedge core_clk);
    rd(8'h08, d);
    `CHK(d[15:0], 16'h1234)
    rd(8'h00, d);
    `CHK(d[15:0], 16'hFFFF)
    wr(8'h00, 16'h0042);
    pins.drive_a(1'b0);
    repeat (4) @(posedge core_clk);
    rd(8'h04, d);
    `CHK(d[15:0], 16'h0042)
    rd(8'h1C, d);
    `CHK(d[5:4], 2'b11)
    // accumulate clock (counting while b low) is refused in capture mode
    wr(8'h18, 16'h00AD);
    wr(8'h14, 16'h001B);
    repeat (20) @(posedge core_clk);
    rd(8'h00, d);
    `CHK(d[15:0], 16'h0042)
    rd(8'h0C, d);
    `CHK(d[15:0], 16'h0000)
    wr(8'h18, 16'h0000);
    wr(8'h20, 16'h000F);
    $display("test capture done");
    // dual timer: pin a rise sets c, counter two underflow sets d
    wr(8'h04, 16'h0001);
    wr(8'h08, 16'h0002);
    wr(8'h1C, 16'h0009);
    wr(8'h00, 16'h0000);
    wr(8'h18, 16'h0092);
    wr(8'h14, 16'h0009);
    repeat (30) @(posedge core_clk);
    rd(8'h1C, d);
    `CHK(d[7:6], 2'b11)
    `CHK(irq1, 1'b1)
    `CHK(irq2, 1'b1)
    $display("test timer done");
    // capture plus timer: slow prescaled counter two, b rising with preset
    wr(8'h10, 16'h001F);
    wr(8'h14, 16'h0008);
    wr(8'h18, 16'h00A3);
    wr(8'h20, 16'h000F);
    wr(8'h0C, 16'h0181);
    pins.pulse_b();
    rd(8'h08, d);
    `CHK(d[15:1], 15'h00C0)
    rd(8'h0C, d);
    `CHK(d[15:1], 15'h7FFF)
    rd(8'h1C, d);
    `CHK(d[5], 1'b1)
    $display("test capture timer done");
    complete_run();
  end
endmodule : testbench
